// ===== hw/swmux_pkg.sv
// Shared constants and types for the quad 2:1 switch control link
package swmux_pkg;

  // Fixed upper address bits, low three come from the select pins
  localparam logic [3:0] ADDR_FIXED = 4'hA;

  // Bit counter values inside one nine-clock byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Command low codes
  localparam logic [6:0] CODE_ALL_A = 7'h00;
  localparam logic [6:0] CODE_ALL_B = 7'h01;
  localparam logic [6:0] CODE_SW_FIRST = 7'h02;
  localparam logic [6:0] CODE_SW_LAST = 7'h09;
  localparam logic [6:0] CODE_MUX_FIRST = 7'h0E;
  localparam logic [6:0] CODE_MUX_LAST = 7'h11;
  localparam logic [6:0] CODE_GPO = 7'h14;
  localparam logic [6:0] CODE_ALL_OFF = 7'h1F;

  // Switch masks, bit 7 is mux1 A down to bit 0 mux4 B
  localparam logic [7:0] MASK_A = 8'hAA;
  localparam logic [7:0] MASK_B = 8'h55;
  localparam logic [7:0] MASK_SW1 = 8'h80;
  localparam logic [7:0] MASK_MUX1 = 8'hC0;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // Default positions of strobe and soft reset inside the second byte
  localparam logic [2:0] STROBE_POS_DEF = 3'h1;
  localparam logic [2:0] RESET_POS_DEF = 3'h0;

  // Readback layout
  localparam logic [7:0] RB_LOW_ZERO = 8'h00;
  localparam int RB_GPO_BIT = 3;

  // Host clock divider: clocks per quarter of an SCL period, minus one
  localparam logic QUARTER_LAST = 1'h1;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_DRIVE = 2'h1;
  localparam logic [1:0] Q_HIGH = 2'h2;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_FIRST = 2'h1;
  localparam logic [1:0] BYTE_SECOND = 2'h2;

  // Device framing states
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_ADDR = 2'b01,
    DEV_WRITE = 2'b10,
    DEV_READ = 2'b11
  } dev_state_t;

  // Host sequencer states
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_START = 2'b01,
    HST_BIT = 2'b10,
    HST_STOP = 2'b11
  } host_state_t;

endpackage

// ===== hw/swmux_link_if.sv
// Two-wire link between the bus master and the switch controller
`timescale 1ns/1ps
interface swmux_link_if;
  logic scl;         // Clock, driven by the master only
  logic sda;         // Resolved data line level
  logic sda_host_o;  // Master data output value
  logic sda_host_oe; // Master drives data line
  logic sda_dev_o;   // Device data output value
  logic sda_dev_oe;  // Device drives data line

  // Open-drain wire with pull-up
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface

// ===== hw/swmux_device.sv
// Switch controller: serial slave, command staging and applied switch state
//
// Behaviour
// RULE1: answer address 1010 plus select pins
// RULE2: write: address, acknowledge, two data bytes
// RULE3: first byte command, second strobe and reset
// RULE4: bit 7 on/off; group and single switch codes
// RULE5: mux open codes; all-off code; reserved
// RULE6: output pin code, reserved without pin
// RULE7: master never closes both mux switches
// RULE8: latest pending command per element wins
// RULE9: hold commands until strobe write applies all
// RULE10: strobe high applies right after strobe bit
// RULE11: master strobes only the last command
// RULE12: soft reset low or power-up opens all
// RULE13: read: address, acknowledge, two status bytes
// RULE14: status 1 closed, 0 open, pin level
// RULE15: high byte holds switch states in order
// RULE16: bit 3 reports output pin, rest empty
// RULE17: slave only, never drives the clock
// RULE18: updates act on strobe bit falling clock
// RULE19: strobe and reset positions are parameters
// RULE20: reserved codes acknowledged, change nothing
// RULE21: unused bits zero, status shows applied only
`timescale 1ns/1ps
module swmux_device #(
  parameter logic HAS_GPO = 1'b1,
  parameter logic [2:0] STROBE_POS = swmux_pkg::STROBE_POS_DEF,
  parameter logic [2:0] RESET_POS = swmux_pkg::RESET_POS_DEF
) (
  input wire logic clk,
  input wire logic reset,
  swmux_link_if.device link,
  input wire logic addr_select_hi,
  input wire logic addr_select_mid,
  input wire logic addr_select_lo,
  output logic [7:0] switch_state,
  output logic general_output_pin
);

  // Counter values at which the strobe and reset bits arrive
  localparam logic [3:0] STROBE_CNT = swmux_pkg::BIT_LAST - {1'b0, STROBE_POS}; // see RULE19
  localparam logic [3:0] RESET_CNT = swmux_pkg::BIT_LAST - {1'b0, RESET_POS}; // see RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Command decode: {gpo hit, gpo value, switch mask, switch value}
  function automatic logic [17:0] decode(input logic [7:0] c, input logic has_gpo);
    logic on;
    logic [6:0] code;
    logic [6:0] off;
    logic [7:0] m;
    logic [7:0] v;
    logic gh;
    logic gv;
    on = c[7];
    code = c[6:0];
    off = 7'h00;
    m = swmux_pkg::MASK_NONE;
    v = swmux_pkg::MASK_NONE;
    gh = 1'b0;
    gv = 1'b0;
    if (code == swmux_pkg::CODE_ALL_A) begin
      m = swmux_pkg::MASK_A; // see RULE4
      v = on ? swmux_pkg::MASK_A : swmux_pkg::MASK_NONE;
    end else if (code == swmux_pkg::CODE_ALL_B) begin
      m = swmux_pkg::MASK_B; // see RULE4
      v = on ? swmux_pkg::MASK_B : swmux_pkg::MASK_NONE;
    end else if (code >= swmux_pkg::CODE_SW_FIRST && code <= swmux_pkg::CODE_SW_LAST) begin
      off = code - swmux_pkg::CODE_SW_FIRST;
      m = swmux_pkg::MASK_SW1 >> off[2:0]; // see RULE4
      v = on ? m : swmux_pkg::MASK_NONE;
    end else if (code >= swmux_pkg::CODE_MUX_FIRST && code <= swmux_pkg::CODE_MUX_LAST) begin
      off = code - swmux_pkg::CODE_MUX_FIRST;
      m = swmux_pkg::MASK_MUX1 >> {off[1:0], 1'b0}; // see RULE5
    end else if (code == swmux_pkg::CODE_ALL_OFF && !on) begin
      m = swmux_pkg::MASK_ALL; // see RULE5
    end else if (code == swmux_pkg::CODE_GPO && has_gpo) begin
      gh = 1'b1; // see RULE6
      gv = on;
    end
    // Anything else leaves mask empty and is still acknowledged
    decode = {gh, gv, m, v}; // see RULE20
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift register clocked by the master's SCL
  typedef struct packed {
    logic [7:0] shift; // Last eight bits seen on SDA
  } link_state_t;

  link_state_t lnk_q;
  link_state_t lnk_d;

  // Shift in one bit per rising clock
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.shift = {lnk_q.shift[6:0], link.sda};
  end

  // Sampled on rising SCL; stable for a whole SCL period afterwards
  always_ff @(posedge link.scl) begin
    lnk_q <= lnk_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain state
  typedef struct packed {
    logic [1:0] scl_s;      // SCL synchroniser, [1] is usable
    logic [1:0] sda_s;      // SDA synchroniser, [1] is usable
    logic scl_p;            // Previous synced SCL
    logic sda_p;            // Previous synced SDA
    logic [2:0] adr_s1;     // Address pin sync, first stage
    logic [2:0] adr_s2;     // Address pin sync, second stage
    swmux_pkg::dev_state_t st; // Framing state
    logic [3:0] cnt;        // Rising clocks within current byte slot
    logic wb;               // Second byte of a write pair is next
    logic [7:0] pend_val;   // Pending switch values
    logic [7:0] pend_mask;  // Switches with a pending command
    logic pend_gpo_hit;     // Output pin command pending
    logic pend_gpo_val;     // Pending output pin level
    logic [7:0] sw;         // Applied switch states
    logic gpo;              // Applied output pin level
    logic [15:0] tx;        // Readback shifter
    logic oe;               // Pull SDA low
    logic do_load;          // Strobe seen, apply at next falling clock
    logic do_rst;           // Soft reset seen, act at next falling clock
  } core_t;

  core_t q;
  core_t d;

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [17:0] dec;   // Decoded command fields
  logic [15:0] rb;    // Readback word

  // Edge and frame condition detection on synchronised lines
  always_comb begin
    rise = q.scl_s[1] & ~q.scl_p;
    fall = ~q.scl_s[1] & q.scl_p;
    start = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
    stop = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];
    dec = decode(lnk_q.shift, HAS_GPO);
  end

  // Readback reflects applied state only, spare bits zero
  always_comb begin
    rb = {q.sw, swmux_pkg::RB_LOW_ZERO}; // see RULE15, see RULE21, see RULE14
    rb[swmux_pkg::RB_GPO_BIT] = q.gpo & HAS_GPO; // see RULE16
  end

  // Next state of the core
  always_comb begin
    d = q;
    // Two-stage synchronisers
    d.scl_s = {q.scl_s[0], link.scl};
    d.sda_s = {q.sda_s[0], link.sda};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    d.adr_s1 = {addr_select_hi, addr_select_mid, addr_select_lo};
    d.adr_s2 = q.adr_s1;
    if (start) begin
      // Start or repeated start: expect address byte
      d.st = swmux_pkg::DEV_ADDR;
      d.cnt = 4'h0;
      d.wb = 1'b0;
      d.oe = 1'b0;
    end else if (stop) begin
      // Stop ends the frame, line released
      d.st = swmux_pkg::DEV_IDLE;
      d.oe = 1'b0;
    end else if (rise && q.st != swmux_pkg::DEV_IDLE) begin
      if (q.cnt == swmux_pkg::BIT_ACK) begin
        // Acknowledge clock; the direction bit now sits one place up
        d.cnt = 4'h0;
        if (q.st == swmux_pkg::DEV_ADDR) begin
          d.st = lnk_q.shift[1] ? swmux_pkg::DEV_READ : swmux_pkg::DEV_WRITE; // see RULE13
        end else if (q.st == swmux_pkg::DEV_READ && q.sda_s[1]) begin
          d.st = swmux_pkg::DEV_IDLE; // Master declined more data
        end
      end else begin
        d.cnt = q.cnt + 4'h1;
        if (q.st == swmux_pkg::DEV_READ) begin
          d.tx = {q.tx[14:0], 1'b1}; // see RULE13
        end
        if (q.st == swmux_pkg::DEV_WRITE && q.wb) begin
          // Control bits of the second byte
          if (q.cnt == STROBE_CNT) begin
            d.do_load = lnk_q.shift[0]; // see RULE10
          end
          if (q.cnt == RESET_CNT) begin
            d.do_rst = ~lnk_q.shift[0]; // see RULE12
          end
        end
        if (q.cnt == swmux_pkg::BIT_LAST) begin
          if (q.st == swmux_pkg::DEV_ADDR) begin
            // Address compare with synced select pins
            if (lnk_q.shift[7:1] == {swmux_pkg::ADDR_FIXED, q.adr_s2}) begin // see RULE1
              d.tx = rb;
            end else begin
              d.st = swmux_pkg::DEV_IDLE;
            end
          end else if (q.st == swmux_pkg::DEV_WRITE) begin
            d.wb = ~q.wb;
            if (!q.wb) begin
              // Command byte: merge into pending, latest wins
              d.pend_mask = q.pend_mask | dec[15:8]; // see RULE3, see RULE8
              d.pend_val = (q.pend_val & ~dec[15:8]) | (dec[7:0] & dec[15:8]); // see RULE8
              if (dec[17]) begin
                d.pend_gpo_hit = 1'b1; // see RULE8
                d.pend_gpo_val = dec[16];
              end
            end
          end
        end
      end
    end else if (fall) begin
      // Staged commands take effect on the falling clock after the strobe
      if (q.do_load) begin
        d.sw = (q.sw & ~q.pend_mask) | (q.pend_val & q.pend_mask); // see RULE9, see RULE18
        d.gpo = q.pend_gpo_hit ? q.pend_gpo_val : q.gpo;
        d.pend_mask = swmux_pkg::MASK_NONE;
        d.pend_gpo_hit = 1'b0;
      end
      if (q.do_rst) begin
        // Soft reset opens all and drops pending work
        d.sw = swmux_pkg::MASK_NONE; // see RULE12
        d.gpo = 1'b0;
        d.pend_mask = swmux_pkg::MASK_NONE;
        d.pend_gpo_hit = 1'b0;
      end
      d.do_load = 1'b0;
      d.do_rst = 1'b0;
      // Data line for the coming bit
      if (q.st == swmux_pkg::DEV_IDLE) begin
        d.oe = 1'b0;
      end else if (q.cnt == swmux_pkg::BIT_ACK) begin
        d.oe = (q.st != swmux_pkg::DEV_READ); // see RULE2, see RULE13
      end else begin
        d.oe = (q.st == swmux_pkg::DEV_READ) & ~q.tx[15]; // see RULE13
      end
    end
  end

  // Core register, power-up state opens every switch
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0; // see RULE12
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.tx <= 16'hFFFF;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; SCL is only ever an input here
  assign switch_state = q.sw; // see RULE14
  assign general_output_pin = q.gpo & HAS_GPO; // see RULE6
  assign link.sda_dev_o = 1'b0; // see RULE17
  assign link.sda_dev_oe = q.oe;

endmodule

// ===== hw/swmux_host.sv
// Bus master: issues two-byte writes and two-byte reads on the link
`timescale 1ns/1ps
module swmux_host (
  input wire logic clk,
  input wire logic reset,
  swmux_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [2:0] req_addr_sel,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_ctrl,
  output logic done,
  output logic ack_error,
  output logic [15:0] rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Master state
  typedef struct packed {
    swmux_pkg::host_state_t st; // Sequencer state
    logic div;                  // Quarter divider
    logic [1:0] qtr;            // Quarter of SCL period
    logic [1:0] byten;          // Byte slot in frame
    logic [3:0] bitn;           // Bit within byte slot
    logic wr;                   // Frame is a write
    logic [7:0] sh;             // Byte being sent
    logic [7:0] cmd;            // Held command byte
    logic [7:0] ctrl;           // Held control byte
    logic [15:0] rdata;         // Read shifter
    logic scl;                  // SCL level
    logic oe;                   // Pull SDA low
    logic err;                  // Missing acknowledge seen
    logic done;                 // Frame finished pulse
    logic [1:0] sda_s;          // SDA synchroniser, [1] usable
  } host_t;

  host_t q;
  host_t d;
  logic tick;
  logic s;

  // Whether the master pulls SDA low for a given bit slot
  function automatic logic drive(input logic wr, input logic [1:0] byten,
                                 input logic [3:0] bitn, input logic [7:0] sh);
    logic rd_slot;
    rd_slot = !wr && byten != swmux_pkg::BYTE_ADDR;
    if (bitn == swmux_pkg::BIT_ACK) begin
      drive = rd_slot && byten == swmux_pkg::BYTE_FIRST; // see RULE13
    end else begin
      drive = !rd_slot && !sh[7]; // see RULE2
    end
  endfunction

  // Sequencer next state
  always_comb begin
    d = q;
    d.sda_s = {q.sda_s[0], link.sda};
    d.done = 1'b0;
    s = q.sda_s[1];
    tick = (q.div == swmux_pkg::QUARTER_LAST);
    d.div = tick ? 1'b0 : q.div + 1'b1;
    if (tick) begin
      d.qtr = q.qtr + 2'h1;
    end
    case (q.st)
      swmux_pkg::HST_IDLE: begin
        d.scl = 1'b1;
        d.oe = 1'b0;
        d.div = 1'b0;
        d.qtr = 2'h0;
        if (req_valid) begin
          d.st = swmux_pkg::HST_START;
          d.wr = req_write;
          d.cmd = req_cmd;
          d.ctrl = req_ctrl;
          d.sh = {swmux_pkg::ADDR_FIXED, req_addr_sel, ~req_write}; // see RULE2, see RULE13
          d.byten = swmux_pkg::BYTE_ADDR;
          d.bitn = 4'h0;
          d.err = 1'b0;
        end
      end
      swmux_pkg::HST_START: begin
        // SDA falls while SCL high, then SCL falls
        if (tick && q.qtr == 2'h0) begin
          d.oe = 1'b1;
        end else if (tick && q.qtr == swmux_pkg::Q_LAST) begin
          d.scl = 1'b0;
          d.st = swmux_pkg::HST_BIT;
        end
      end
      swmux_pkg::HST_BIT: begin
        if (tick && q.qtr == 2'h0) begin
          d.oe = drive(q.wr, q.byten, q.bitn, q.sh); // see RULE11
        end else if (tick && q.qtr == swmux_pkg::Q_DRIVE) begin
          d.scl = 1'b1;
        end else if (tick && q.qtr == swmux_pkg::Q_LAST) begin
          d.scl = 1'b0;
          if (q.bitn != swmux_pkg::BIT_ACK) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.bitn = q.bitn + 4'h1;
            if (!q.wr && q.byten != swmux_pkg::BYTE_ADDR) begin
              d.rdata = {q.rdata[14:0], s};
            end
          end else begin
            d.bitn = 4'h0;
            d.byten = q.byten + 2'h1;
            d.sh = (q.byten == swmux_pkg::BYTE_ADDR) ? q.cmd : q.ctrl;
            if ((q.wr || q.byten == swmux_pkg::BYTE_ADDR) && s) begin
              d.err = 1'b1; // No acknowledge from device
              d.st = swmux_pkg::HST_STOP;
            end else if (q.byten == swmux_pkg::BYTE_SECOND) begin
              d.st = swmux_pkg::HST_STOP;
            end
          end
        end
      end
      default: begin
        // Stop: SDA low, SCL high, then SDA rises
        if (tick && q.qtr == 2'h0) begin
          d.oe = 1'b1;
        end else if (tick && q.qtr == swmux_pkg::Q_DRIVE) begin
          d.scl = 1'b1;
        end else if (tick && q.qtr == swmux_pkg::Q_HIGH) begin
          d.oe = 1'b0;
        end else if (tick && q.qtr == swmux_pkg::Q_LAST) begin
          d.st = swmux_pkg::HST_IDLE;
          d.done = 1'b1;
        end
      end
    endcase
  end

  // Master register
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.scl <= 1'b1;
      q.sda_s <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign req_ready = (q.st == swmux_pkg::HST_IDLE);
  assign done = q.done;
  assign ack_error = q.err;
  assign rd_data = q.rdata;
  assign link.scl = q.scl;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = q.oe;

endmodule

// ===== verif/swmux_link_properties.sv
// Concurrent checks on the two-wire link between master and switch controller
`timescale 1ns/1ps
module swmux_link_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  // Clock falls since the last start condition, saturating at the top; reset parks it there
  logic [5:0] falls_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Count clock falls inside a frame
  always_ff @(posedge clk) begin
    if (reset) begin
      falls_q <= 6'h3F;
    end else if (scl && $past(scl) && $fell(sda)) begin
      // Start condition restarts the count
      falls_q <= 6'h00;
    end else if ($fell(scl) && falls_q != 6'h3F) begin
      falls_q <= falls_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Named steps of the clock and framing
  sequence clk_fell_s;
    $fell(scl);
  endsequence

  sequence low_phase_s;
    (!scl)[*4] ##1 scl;
  endsequence

  sequence stop_s;
    scl && $rose(sda);
  endsequence

  property low_phase_p;
    clk_fell_s |-> low_phase_s;
  endproperty

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  dev_pulls_low_a: assert property (sda_dev_oe |-> !sda)
    else $error("device drive does not pull the data line low");
  host_pulls_low_a: assert property (sda_host_oe |-> !sda)
    else $error("master drive does not pull the data line low");
  clk_high_a: assert property ($rose(scl) |-> scl[*4])
    else $error("clock high phase shorter than four cycles");
  clk_low_a: assert property (low_phase_p)
    else $error("clock low phase is not four cycles");
  dev_change_low_a: assert property ($changed(sda_dev_oe) |-> !$past(scl))
    else $error("device changed data line while clock high");
  dev_lag_a: assert property ($changed(sda_dev_oe) |->
    ($past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
    else $error("device data change not two to four cycles after a clock fall");
  addr_quiet_a: assert property (falls_q < 6'h09 |-> !sda_dev_oe)
    else $error("device drove data line during the address byte");
  idle_release_a: assert property (stop_s |-> (!sda_dev_oe)[*8])
    else $error("device drove data line after a stop");
endmodule

// ===== verif/test_i2c_quad_mux_switch_control.sv
// Self-checking bench: master and switch controller joined over the link
`timescale 1ns/1ps
module test_i2c_quad_mux_switch_control;
  // One table row: command, strobe, and the applied state it should leave
  typedef struct packed {
    logic [7:0] cmd;
    logic stb;
    logic [7:0] sw;
    logic gpo;
  } row_t;

  logic clk; // Core clock
  logic reset; // Synchronous reset
  logic [2:0] dev_sel; // Device select pins, high to low
  logic req_valid, req_write; // Request strobe and direction
  logic [2:0] req_addr_sel; // Select bits the master addresses
  logic [7:0] req_cmd, req_ctrl; // Command and control bytes
  logic req_ready, done, ack_error; // Master status
  logic [15:0] rd_data; // Status word read back
  logic [7:0] switch_state; // Applied switch states
  logic general_output_pin; // Applied output pin
  int fails; // Mismatches
  int n_tests; // Comparisons
  row_t rows [24]; // Ordinary cases

  swmux_link_if u_swmux_link_if ();

  swmux_device u_swmux_device (.clk(clk), .reset(reset), .link(u_swmux_link_if),
    .addr_select_hi(dev_sel[2]), .addr_select_mid(dev_sel[1]), .addr_select_lo(dev_sel[0]),
    .switch_state(switch_state), .general_output_pin(general_output_pin));

  swmux_host u_swmux_host (.clk(clk), .reset(reset), .link(u_swmux_link_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr_sel(req_addr_sel), .req_cmd(req_cmd), .req_ctrl(req_ctrl), .done(done),
    .ack_error(ack_error), .rd_data(rd_data));

  swmux_link_properties u_swmux_link_properties (.clk(clk), .reset(reset),
    .scl(u_swmux_link_if.scl), .sda(u_swmux_link_if.sda),
    .sda_host_o(u_swmux_link_if.sda_host_o), .sda_host_oe(u_swmux_link_if.sda_host_oe),
    .sda_dev_o(u_swmux_link_if.sda_dev_o), .sda_dev_oe(u_swmux_link_if.sda_dev_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Clock generator
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One whole frame on the master's request port, bounded wait for done
  task automatic frame(input logic wr, input logic [2:0] sel, input logic [7:0] cmd,
                       input logic [7:0] ctrl);
    int i;
    while (req_ready !== 1'h1) @(negedge clk);
    req_write = wr;
    req_addr_sel = sel;
    req_cmd = cmd;
    req_ctrl = ctrl;
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if (done === 1'h1) break;
    end
    if (i == 400) begin
      fails++;
      $display("[ERR] %0t frame never finished", $time);
    end
  endtask

  // Write one command with the strobe and soft reset bits placed in byte two
  task automatic wr(input logic [2:0] sel, input logic [7:0] cmd, input logic stb,
                    input logic rst_n);
    logic [7:0] ctrl;
    ctrl = 8'h00;
    ctrl[swmux_pkg::STROBE_POS_DEF] = stb;
    ctrl[swmux_pkg::RESET_POS_DEF] = rst_n;
    frame(1'h1, sel, cmd, ctrl);
  endtask

  // Applied state at the pins, then the same state through a read
  task automatic expect_state(input logic [7:0] sw, input logic gpo);
    chk({8'h00, switch_state}, {8'h00, sw}, "switch state");
    chk({15'h0000, general_output_pin}, {15'h0000, gpo}, "output pin");
    frame(1'h0, dev_sel, 8'h00, 8'h00);
    chk(rd_data, {sw, 4'h0, gpo, 3'h0}, "readback");
    chk({15'h0000, ack_error}, 16'h0000, "read acknowledge");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung frame
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fails = 0;
    n_tests = 0;
    reset = 1'h1;
    dev_sel = 3'h6;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr_sel = 3'h0;
    req_cmd = 8'h00;
    req_ctrl = 8'h00;
    // Every code group, both polarities except all-B off; no mux ever gets both closed
    rows = '{{8'h80, 1'h1, 8'hAA, 1'h0}, {8'h00, 1'h1, 8'h00, 1'h0},
             {8'h81, 1'h1, 8'h55, 1'h0}, {8'h0E, 1'h1, 8'h15, 1'h0},
             {8'h8F, 1'h1, 8'h05, 1'h0}, {8'h10, 1'h1, 8'h01, 1'h0},
             {8'h91, 1'h1, 8'h00, 1'h0}, {8'h82, 1'h1, 8'h80, 1'h0},
             {8'h85, 1'h1, 8'h90, 1'h0}, {8'h86, 1'h1, 8'h98, 1'h0},
             {8'h89, 1'h1, 8'h99, 1'h0}, {8'h03, 1'h1, 8'h99, 1'h0},
             {8'h94, 1'h1, 8'h99, 1'h1}, {8'h14, 1'h1, 8'h99, 1'h0},
             {8'h8A, 1'h1, 8'h99, 1'h0}, {8'h92, 1'h1, 8'h99, 1'h0},
             {8'h9F, 1'h1, 8'h99, 1'h0}, {8'h1F, 1'h1, 8'h00, 1'h0},
             {8'h83, 1'h1, 8'h40, 1'h0}, {8'h02, 1'h1, 8'h40, 1'h0},
             {8'h84, 1'h1, 8'h60, 1'h0}, {8'h07, 1'h1, 8'h60, 1'h0},
             {8'h88, 1'h1, 8'h62, 1'h0}, {8'h04, 1'h1, 8'h42, 1'h0}};
    repeat (12) @(negedge clk);
    reset = 1'h0;
    repeat (4) @(negedge clk);
    expect_state(8'h00, 1'h0);
    foreach (rows[i]) begin
      wr(dev_sel, rows[i].cmd, rows[i].stb, 1'h1);
      expect_state(rows[i].sw, rows[i].gpo);
    end
    // Staged commands: nothing shows before the strobe, the later command wins
    wr(dev_sel, 8'h82, 1'h0, 1'h1);
    expect_state(8'h42, 1'h0);
    wr(dev_sel, 8'h02, 1'h0, 1'h1);
    wr(dev_sel, 8'h94, 1'h0, 1'h1);
    wr(dev_sel, 8'h87, 1'h1, 1'h1);
    expect_state(8'h46, 1'h1);
    // Soft reset opens everything and drops staged commands
    wr(dev_sel, 8'h85, 1'h0, 1'h1);
    wr(dev_sel, 8'h1E, 1'h0, 1'h0);
    expect_state(8'h00, 1'h0);
    wr(dev_sel, 8'h8A, 1'h1, 1'h1);
    expect_state(8'h00, 1'h0);
    wr(dev_sel, 8'h80, 1'h1, 1'h1);
    wr(dev_sel, 8'h94, 1'h1, 1'h0);
    expect_state(8'h00, 1'h0);
    // Select pins in reversed order must not be answered
    wr(3'h3, 8'h80, 1'h1, 1'h1);
    chk({15'h0000, ack_error}, 16'h0001, "foreign write answered");
    frame(1'h0, 3'h3, 8'h00, 8'h00);
    chk({15'h0000, ack_error}, 16'h0001, "foreign read answered");
    expect_state(8'h00, 1'h0);
    end_of_test();
  end
endmodule
